// [pkg/tco_pkg.sv]
// Constants, register map and state encoding for the transmit checksum offload engine
package tco_pkg;
    // APB register map, byte addresses
    localparam int unsigned APB_AW        = 12;
    localparam logic [11:0] CTRL_OFF      = 12'h000;
    localparam logic [11:0] STAT_OFF      = 12'h004;
    localparam logic [11:0] CNT_OFF       = 12'h008;
    localparam int unsigned CTRL_EN_BIT   = 0;
    localparam int unsigned CTRL_MODE_BIT = 1;
    localparam logic [1:0]  CTRL_RESET    = 2'h0;
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_SUM_LSB  = 16;

    // Command words ahead of each frame
    localparam int unsigned FIRST_SEG_BIT = 13;   // First segment flag in command A
    localparam int unsigned SUM_REQ_BIT   = 14;   // Checksum request flag in command B
    localparam int unsigned LEN_W         = 14;   // Packet length in command B [13:0]

    // Checksum header word
    localparam int unsigned OFF_W         = 12;
    localparam int unsigned INS_LSB       = 16;   // Insert offset in [27:16]
    localparam int unsigned START_LSB     = 0;    // Start offset in [11:0]
    localparam logic [13:0] HDR_BYTES     = 14'h0004;

    // Frame store
    localparam int unsigned MEM_AW        = 10;
    localparam int unsigned MEM_DEPTH     = 1024;

    typedef enum logic [6:0] {
        ST_CMDA  = 7'h01,
        ST_CMDB  = 7'h02,
        ST_HDR   = 7'h04,
        ST_DATA  = 7'h08,
        ST_SENDA = 7'h10,
        ST_SENDB = 7'h20,
        ST_SENDD = 7'h40
    } tco_state_t;
endpackage

// [hdl/tco_sum_acc.sv]
// One's-complement 16-bit accumulator fed one masked 32-bit word per cycle
`timescale 1ns/1ps
module tco_sum_acc (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        clear,
    input  wire logic        wordValid,
    input  wire logic [31:0] wordData,
    input  wire logic [3:0]  byteMask,
    output logic      [15:0] sum
);
    // Fold an 18-bit sum back to 16 bits with end-around carry
    function automatic logic [15:0] fold(input logic [17:0] t);
        logic [16:0] f;
        f    = {1'b0, t[15:0]} + {15'h0000, t[17:16]};
        fold = f[15:0] + {15'h0000, f[16]};
    endfunction

    logic [7:0]  b0, b1, b2, b3;
    logic [17:0] total;

    // Bytes outside the summed region count as zero, which also pads an odd tail
    assign b0    = byteMask[0] ? wordData[7:0]   : 8'h00;
    assign b1    = byteMask[1] ? wordData[15:8]  : 8'h00;
    assign b2    = byteMask[2] ? wordData[23:16] : 8'h00;
    assign b3    = byteMask[3] ? wordData[31:24] : 8'h00;
    assign total = {2'b00, sum} + {2'b00, b1, b0} + {2'b00, b3, b2};   // see R21

    // Running sum, even byte of each pair as low byte
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sum <= 16'h0000;
        end else if (clear) begin
            sum <= 16'h0000;
        end else if (wordValid) begin
            sum <= fold(total);   // see R15
        end
    end
endmodule // tco_sum_acc

// [hdl/tco_engine.sv]
// Transmit checksum offload engine: store-and-forward with checksum insertion
//
// Summary of operation
// R01: Checksum header bits 27:16 give insert offset; two bytes there get the checksum.
// R02: Host never places the insert offset in the first 14 or last 4 bytes.
// R03: Checksum header bits 11:0 give the byte offset where summation starts.
// R04: Host never places the start offset in the first 14 or last 4 bytes.
// R05: With offload enabled the checksum header word is dropped, never transmitted.
// R06: Host adds four bytes to the packet length for the checksum header.
// R07: Host stops and flushes the transmitter before toggling offload enable.
// R08: The checksum request flag is evaluated anew for every frame.
// R09: Host changes the offload mode only with the transmit path drained.
// R10: Host places the checksum header on a 32-bit word boundary.
// R11: Buffer and packet lengths both include the checksum header.
// R12: The checksum header travels alone as the first buffer of a frame.
// R13: Host applies no start offset to the buffer holding the header.
// R14: Host sets first segment flag only on a frame's first buffer.
// R15: Sum 16-bit words one's-complement from start offset; insert the inverse.
// R16: A computed zero checksum is inserted as zero, never replaced by all ones.
// R17: Host never requests hardware checksums for UDP over IPv6.
// R18: Checksum only when enabled, first segment flag set and request flag set.
// R19: Request flag clear in the first command pair passes the frame unchanged.
// R20: Summation runs from start offset through the frame's last byte.
// R21: Pairs take first byte as low byte; an odd tail pads with zero.
// R22: Reserved bits of the checksum header are ignored.
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
module tco_engine (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Word stream from the transmit data FIFO
    input  wire logic        inValid,
    input  wire logic [31:0] inData,
    input  wire logic        inLast,
    output logic             inReady,
    // Word stream towards the MAC
    output logic             outValid,
    output logic      [31:0] outData,
    output logic             outLast,
    input  wire logic        outReady
);
    // Mask of lanes of one word that lie inside [start, len)
    function automatic logic [3:0] laneMask(input logic [tco_pkg::MEM_AW-1:0] idx,
                                            input logic [tco_pkg::OFF_W-1:0]  start,
                                            input logic [tco_pkg::LEN_W-1:0]  len);
        logic [tco_pkg::LEN_W-1:0] pos;
        laneMask = 4'h0;
        for (int k = 0; k < 4; k++) begin
            pos         = {2'b00, idx, k[1:0]};
            laneMask[k] = (pos >= {2'b00, start}) && (pos < len);   // see R20
        end
    endfunction

    // Overwrite the two bytes at the insert offset, first one low
    function automatic logic [31:0] patch(input logic [31:0]                 w,
                                          input logic [tco_pkg::MEM_AW-1:0] idx,
                                          input logic [tco_pkg::OFF_W-1:0]  ins,
                                          input logic [15:0]                chk);
        logic [tco_pkg::OFF_W-1:0] pos;
        patch = w;
        for (int k = 0; k < 4; k++) begin
            pos = {idx, k[1:0]};
            if (pos == ins) begin
                patch[8*k +: 8] = chk[7:0];   // see R01
            end else if (pos == ins + 12'h001) begin
                patch[8*k +: 8] = chk[15:8];  // see R01
            end
        end
    endfunction

    tco_pkg::tco_state_t         state_r, state_nxt;
    logic [31:0]                 frameMem [tco_pkg::MEM_DEPTH];
    logic [31:0]                 cmdA_r, cmdB_r;
    logic [1:0]                  ctrl_r;
    logic                        enFrame_r, usesHdr_r, doSum_r;
    logic [tco_pkg::OFF_W-1:0]   insOff_r, startOff_r;
    logic [tco_pkg::LEN_W-1:0]   dataLen_r;
    logic [tco_pkg::MEM_AW-1:0]  wrIdx_r, rdIdx_r, lastIdx_r;
    logic [15:0]                 lastSum_r, frameCnt_r;
    logic [15:0]                 rawSum, alignedSum, finalSum;
    logic                        inFire, outFree, memFull, sendLast, outBusyNxt;
    logic                        apbAccess, apbWrite, hitCtrl, hitStat, hitCnt;
    logic [31:0]                 readMux;

    // Handshake and decode terms
    assign inFire    = inValid & inReady;
    assign outFree   = ~outValid | outReady;
    assign memFull   = (wrIdx_r == tco_pkg::MEM_AW'(tco_pkg::MEM_DEPTH - 1));
    assign sendLast  = (rdIdx_r == lastIdx_r);
    // Output word still pending next cycle; input must wait until the last word has left
    assign outBusyNxt = outFree ? ((state_r == tco_pkg::ST_SENDA) || (state_r == tco_pkg::ST_SENDB) ||
                                   (state_r == tco_pkg::ST_SENDD))
                                : outValid;
    assign apbAccess = psel & penable & ~pready;
    assign apbWrite  = psel & penable & pready & pwrite;
    assign hitCtrl   = (paddr == tco_pkg::CTRL_OFF);
    assign hitStat   = (paddr == tco_pkg::STAT_OFF);
    assign hitCnt    = (paddr == tco_pkg::CNT_OFF);

    // Sum was taken with frame-even bytes low; an odd start swaps the pair order
    assign alignedSum = startOff_r[0] ? {rawSum[7:0], rawSum[15:8]} : rawSum;   // see R21
    assign finalSum   = ~alignedSum;   // see R15, no zero substitution see R16

    tco_sum_acc u_sum (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .clear     (state_r == tco_pkg::ST_CMDA),
        .wordValid (inFire && state_r == tco_pkg::ST_DATA && doSum_r),
        .wordData  (inData),
        .byteMask  (laneMask(wrIdx_r, startOff_r, dataLen_r)),
        .sum       (rawSum)
    );

    // Next state of the frame sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            tco_pkg::ST_CMDA:  if (inFire) state_nxt = tco_pkg::ST_CMDB;
            tco_pkg::ST_CMDB:  if (inFire) state_nxt = usesHdr_r ? tco_pkg::ST_HDR : tco_pkg::ST_DATA;
            tco_pkg::ST_HDR:   if (inFire) state_nxt = tco_pkg::ST_DATA;
            tco_pkg::ST_DATA:  if (inFire && inLast) state_nxt = tco_pkg::ST_SENDA;
            tco_pkg::ST_SENDA: if (outFree) state_nxt = tco_pkg::ST_SENDB;
            tco_pkg::ST_SENDB: if (outFree) state_nxt = tco_pkg::ST_SENDD;
            tco_pkg::ST_SENDD: if (outFree && sendLast) state_nxt = tco_pkg::ST_CMDA;
            default:           state_nxt = tco_pkg::ST_CMDA;
        endcase
    end

    // Sequencer state and input acceptance, ready comes straight from a flop
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_r <= tco_pkg::ST_CMDA;
            inReady <= 1'b0;
        end else begin
            state_r <= state_nxt;
            inReady <= ((state_nxt == tco_pkg::ST_CMDA) || (state_nxt == tco_pkg::ST_CMDB) ||
                        (state_nxt == tco_pkg::ST_HDR)  || (state_nxt == tco_pkg::ST_DATA)) && !outBusyNxt;
        end
    end

    // Per-frame command capture; enable is sampled once per frame
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cmdA_r    <= 32'h00000000;
            cmdB_r    <= 32'h00000000;
            enFrame_r <= 1'b0;
            usesHdr_r <= 1'b0;
            doSum_r   <= 1'b0;
            dataLen_r <= '0;
        end else if (inFire && state_r == tco_pkg::ST_CMDA) begin
            cmdA_r    <= inData;
            enFrame_r <= ctrl_r[tco_pkg::CTRL_EN_BIT];
            usesHdr_r <= ctrl_r[tco_pkg::CTRL_EN_BIT] & inData[tco_pkg::FIRST_SEG_BIT];
        end else if (inFire && state_r == tco_pkg::ST_CMDB) begin
            cmdB_r    <= inData;
            doSum_r   <= usesHdr_r & inData[tco_pkg::SUM_REQ_BIT];   // see R18, R08, R19
            dataLen_r <= usesHdr_r ? inData[tco_pkg::LEN_W-1:0] - tco_pkg::HDR_BYTES   // see R11
                                   : inData[tco_pkg::LEN_W-1:0];
        end
    end

    // Checksum header fields, reserved bits dropped
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            insOff_r   <= '0;
            startOff_r <= '0;
        end else if (state_r == tco_pkg::ST_CMDA) begin
            insOff_r   <= '0;
            startOff_r <= '0;
        end else if (inFire && state_r == tco_pkg::ST_HDR) begin
            insOff_r   <= inData[tco_pkg::INS_LSB +: tco_pkg::OFF_W];     // see R01, R22
            startOff_r <= inData[tco_pkg::START_LSB +: tco_pkg::OFF_W];   // see R03, R22
        end
    end

    // Frame store; the header word never enters it, so it is never sent
    always_ff @(posedge sys_clk) begin
        if (inFire && state_r == tco_pkg::ST_DATA) begin
            frameMem[wrIdx_r] <= inData;   // see R05
        end
    end

    // Write and read pointers; words past the store size overwrite the last slot
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wrIdx_r   <= '0;
            rdIdx_r   <= '0;
            lastIdx_r <= '0;
        end else begin
            if (state_r == tco_pkg::ST_CMDA) begin
                wrIdx_r <= '0;
                rdIdx_r <= '0;
            end else if (inFire && state_r == tco_pkg::ST_DATA) begin
                lastIdx_r <= wrIdx_r;
                if (!memFull) begin
                    wrIdx_r <= wrIdx_r + 1'b1;
                end
            end else if (outFree && state_r == tco_pkg::ST_SENDD) begin
                rdIdx_r <= rdIdx_r + 1'b1;
            end
        end
    end

    // Output word register, held while the MAC stalls
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            outValid <= 1'b0;
            outData  <= 32'h00000000;
            outLast  <= 1'b0;
        end else if (outFree) begin
            outValid <= (state_r == tco_pkg::ST_SENDA) || (state_r == tco_pkg::ST_SENDB) ||
                        (state_r == tco_pkg::ST_SENDD);
            outLast  <= (state_r == tco_pkg::ST_SENDD) && sendLast;
            case (state_r)
                tco_pkg::ST_SENDA: outData <= cmdA_r;
                tco_pkg::ST_SENDB: outData <= cmdB_r;
                tco_pkg::ST_SENDD: outData <= doSum_r ? patch(frameMem[rdIdx_r], rdIdx_r, insOff_r, finalSum)
                                                      : frameMem[rdIdx_r];   // see R19
                default:           outData <= outData;
            endcase
        end
    end

    // Statistics: last inserted checksum and count of offloaded frames
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            lastSum_r  <= 16'h0000;
            frameCnt_r <= 16'h0000;
        end else if (state_r == tco_pkg::ST_SENDA && outFree && doSum_r) begin
            lastSum_r  <= finalSum;
            frameCnt_r <= frameCnt_r + 16'h0001;
        end
    end

    // Register read data; bits not listed read as zero
    always_comb begin
        readMux = 32'h00000000;
        if (hitCtrl) begin
            readMux[1:0] = ctrl_r;
        end else if (hitStat) begin
            readMux[tco_pkg::STAT_BUSY_BIT]            = (state_r != tco_pkg::ST_CMDA) | outValid;
            readMux[tco_pkg::STAT_SUM_LSB +: 16]       = lastSum_r;
            readMux[tco_pkg::STAT_BUSY_BIT + 1]        = enFrame_r;
        end else if (hitCnt) begin
            readMux[15:0] = frameCnt_r;
        end
    end

    // APB slave: one wait state, answer in the second access cycle
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready  <= apbAccess;
            prdata  <= (apbAccess && !pwrite) ? readMux : 32'h00000000;
            pslverr <= apbAccess & ~(hitCtrl | hitStat | hitCnt);
        end
    end

    // Control register; host only changes it with the path drained
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ctrl_r <= tco_pkg::CTRL_RESET;
        end else if (apbWrite && hitCtrl) begin
            ctrl_r <= pwdata[1:0];   // see R07, R09
        end
    end
endmodule // tco_engine

// [test/tco_engine_props.sv]
// Port-level checks of the transmit checksum offload engine
`timescale 1ns/1ps
module tco_engine_props (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        inValid,
    input wire logic [31:0] inData,
    input wire logic        inLast,
    input wire logic        inReady,
    input wire logic        outValid,
    input wire logic [31:0] outData,
    input wire logic        outLast,
    input wire logic        outReady
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    // Bus answers after one wait state, for one cycle only
    a_apb_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("pready wait state wrong");
    a_pready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_slverr_pair: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_prdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata outside answer");
    // A stalled word must not change, or the MAC could sample a torn value
    a_out_hold: assert property (outValid && !outReady |=> outValid && $stable(outData) && $stable(outLast))
        else $error("output word changed while stalled");
    // Store and forward: no input while a frame goes out
    a_in_refused: assert property (outValid |-> !inReady)
        else $error("input accepted during send");
    a_send_start: assert property (inValid && inReady && inLast |-> ##[1:3] outValid)
        else $error("send did not start");
    a_frame_end: assert property (outValid && outReady && outLast |=> !outValid ##[0:2] inReady)
        else $error("frame end not released");

    cover property (outValid && outReady && outLast);
    cover property (outValid && !outReady);
    cover property (pslverr);
endmodule // tco_engine_props

// [test/tco_host_model.sv]
// Host-side model: queues command words, checksum header and payload
`timescale 1ns/1ps
module tco_host_model (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        inReady,
    output logic             inValid,
    output logic      [31:0] inData,
    output logic             inLast
);
    logic [32:0] q[$];
    logic [7:0]  fb[0:259];
    logic        slow = 1'b0;

    // One frame; a zero seed keeps bytes the caller preset in fb
    task automatic frame(input logic fs, ck, hdr, input logic [11:0] st, ins, input int n, seed);
        int i;
        for (i = 0; seed != 0 && i < n + 4; i++) fb[i] = 8'(i * seed + 17);
        q.push_back({1'b0, 18'h0, fs, 13'h0});
        q.push_back({1'b0, 17'h0, ck, 14'(n + (hdr ? 4 : 0))});
        // Header alone and word aligned; reserved bits set on purpose
        if (hdr) q.push_back({5'h0a, ins, 4'h5, st});
        for (i = 0; i < n; i += 4) q.push_back({i + 4 >= n, fb[i+3], fb[i+2], fb[i+1], fb[i]});
    endtask

    // Idle data toggles so a stale word never passes for a valid one
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            {inValid, inLast, inData} <= 34'h0;
        end else if (!inValid || inReady) begin
            if (q.size() > 0 && !(slow && inValid)) begin
                {inValid, inLast, inData} <= {1'b1, q.pop_front()};
            end else begin
                {inValid, inLast, inData} <= {2'b00, ~inData};
            end
        end
    end
endmodule // tco_host_model

// [test/tb_tco_engine.sv]
// Self-checking bench for the transmit checksum offload engine
`timescale 1ns/1ps
module tb_tco_engine;
    logic        sys_clk = 1'b0;
    logic        reset, psel, penable, pwrite, pready, pslverr, stall;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, inData, outData;
    logic        inValid, inLast, inReady, outValid, outLast, outReady;
    logic [32:0] rsp, eq[$], oq[$];
    logic [15:0] lastChk;
    int          n_fail = 0, cmp_count = 0, i;

    tco_engine uut (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .inValid(inValid), .inData(inData), .inLast(inLast), .inReady(inReady), .outValid(outValid),
        .outData(outData), .outLast(outLast), .outReady(outReady));
    tco_host_model host (.sys_clk(sys_clk), .reset(reset), .inReady(inReady), .inValid(inValid),
        .inData(inData), .inLast(inLast));

    always #5 sys_clk = ~sys_clk;
    // MAC side: ready toggles while stalling, words are logged as taken
    always @(posedge sys_clk) begin
        outReady <= stall ? ~outReady : 1'b1;
        if (outValid === 1'b1 && outReady) oq.push_back({outLast, outData});
    end

    task automatic chk(input string nm, input logic [32:0] ex, got);
        cmp_count++;
        if (got !== ex) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, wd};
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rsp = {pslverr, prdata};
        {psel, penable} <= 2'b00;
    endtask

    // Queues a frame and works out the words the MAC should see
    task automatic run(input logic fs, ck, hdr, input logic [11:0] st, ins, input int n, seed);
        logic [7:0]  b[0:259];
        logic [16:0] s;
        host.frame(fs, ck, hdr, st, ins, n, seed);
        for (i = 0; i < n + 4; i++) b[i] = host.fb[i];
        s = 17'h0;
        for (i = st; i < n; i += 2) begin
            s = s + {1'b0, (i + 1 < n) ? b[i+1] : 8'h00, b[i]};
            s = {1'b0, s[15:0]} + 17'(s[16]);
        end
        if (hdr && ck) begin
            b[ins] = ~s[7:0];
            b[ins+1] = ~s[15:8];
            lastChk = ~s[15:0];
        end
        eq.push_back({1'b0, 18'h0, fs, 13'h0});
        eq.push_back({1'b0, 17'h0, ck, 14'(n + (hdr ? 4 : 0))});
        for (i = 0; i < n; i += 4) eq.push_back({i + 4 >= n, b[i+3], b[i+2], b[i+1], b[i]});
    endtask

    task automatic drain();
        while (oq.size() < eq.size()) @(posedge sys_clk);
        while (eq.size() > 0) chk("frame word", eq.pop_front(), oq.pop_front());
    endtask

    task automatic tally_and_finish();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Whole run is a few hundred cycles; this only trips on a hang
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {reset, stall} = 2'b10;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        run(1, 1, 0, 12'h00e, 12'h014, 30, 5);
        drain();
        apb(1, tco_pkg::CTRL_OFF, 32'h3);
        apb(0, tco_pkg::CTRL_OFF, 32'h0);
        chk("ctrl", 33'h3, rsp);
        run(1, 1, 1, 12'h00e, 12'h018, 41, 37);
        drain();
        // Back to back, flag cleared then set, both sides stalling
        {stall, host.slow} <= 2'b11;
        run(1, 0, 1, 12'h00e, 12'h018, 36, 13);
        run(1, 1, 1, 12'h00f, 12'h014, 32, 91);
        drain();
        {stall, host.slow} <= 2'b00;
        // Summed bytes fold to all ones, so the checksum comes out zero
        for (i = 0; i < 28; i++) host.fb[i] = (i == 14 || i == 15) ? 8'hff : 8'h00;
        run(1, 1, 1, 12'h00e, 12'h010, 24, 0);
        run(0, 1, 0, 12'h00e, 12'h010, 20, 3);
        drain();
        apb(0, tco_pkg::STAT_OFF, 32'h0);
        chk("status", {1'b0, lastChk, 16'h0002}, rsp);
        apb(0, tco_pkg::CNT_OFF, 32'h0);
        chk("count", 33'h3, rsp);
        apb(1, 12'h010, 32'h1);
        chk("unmapped write", 33'h100000000, rsp);
        apb(0, 12'h00c, 32'h0);
        chk("unmapped read", 33'h100000000, rsp);
        chk("spare words", 33'h0, 33'(oq.size()));
        tally_and_finish();
    end
endmodule // tb_tco_engine

bind tco_engine tco_engine_props u_props (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .inValid(inValid), .inData(inData), .inLast(inLast), .inReady(inReady), .outValid(outValid),
    .outData(outData), .outLast(outLast), .outReady(outReady));
